// ===== hdl/lcr_cfg_regs.sv
// How it works
// R1: Slave only, standard rate, seven-bit address, eight-bit bytes.
// R2: The index byte after the address changes nothing.
// R3: Bytes move in order from offset zero; master may stop anywhere.
// R4: Three address bits come from strap inputs, the rest fixed.
// R5: Write bytes fill successive registers until STOP.
// R6: Per-channel bit 7 is A0, then B0, A1, B1, A2, B2, A3, B3.
// R7: Signal-detect bits are read-only live detector levels.
// R8: Spare byte one reads zero, ignores writes.
// R9: Bits 7..4 pick loopback (0) per lane pair; loaded from strap.
// R10: Bits 3 and 2 pick half-bit de-emphasis; bits 1..0 read-only.
// R11: Input-off bit 1 disables that input; reset value zero.
// R12: Output-off bit 1 disables that output; reset value zero.
// R13: Spare byte five is plain storage; reset value all ones.
// R14: Channel-on bits are active high, loaded from power-down strap.
// R15: Bus writes only while mode is low; high mode follows straps.
// R16: Never stretch the clock; acknowledge every byte received.
// R17: Reads and writes start at offset zero; first write byte dropped.
// R18: Address is 11, strap, 00, strap, strap; R/W 1 means read.
// R19: Pointer clears on every START; read-only bits ignore writes.
// R20: Past the last register, writes drop and reads return filler.
`timescale 1ns/100ps
module lcr_cfg_regs
  import lcr_pkg::*;
(
  input  wire logic       i_clk,                // System clock, 50 MHz.
  input  wire logic       i_rstn,               // Async reset, active low.
  input  wire logic       i_scl,                // Bus serial clock.
  input  wire logic       i_sda,                // Bus data line level.
  output logic            o_sda,                // Data drive level, low.
  output logic            o_sda_oe,             // High pulls data low.
  input  wire logic       i_cfg_mode,           // High: straps rule.
  input  wire logic [7:0] i_signal_present_bit, // Live level detectors.
  input  wire lcr_strap_t i_straps,             // Strap pin levels.
  output lcr_cfg_t        o_cfg                 // Operating configuration.
);

  localparam int SYNC_W = 36;

  // Link side, clocked on the rising serial clock edge.
  typedef struct packed {
    lcr_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [3:0] ptr;
    logic       ack_due;
    logic       wr_tgl;
    logic [3:0] wr_idx;
    logic [7:0] wr_dat;
    logic       rd_tgl;
    logic [3:0] rd_idx;
  } lcr_link_t;

  // Link side, clocked on the falling serial clock edge.
  typedef struct packed {
    logic [7:0] sh;
    logic       oe;
    logic       lvl;
  } lcr_tx_t;

  // System clock side.
  typedef struct packed {
    logic       scl_p;
    logic       sda_p;
    logic       wr_p;
    logic       rd_p;
    logic [1:0] init_cnt;
    logic       init_done;
    logic [5:0] clr_cnt;
    logic       link_rstn;
    logic [6:0] addr;
    logic [7:0] rd_byte;
    logic [7:0] spare5;
    lcr_cfg_t   cfg;
  } lcr_sys_t;

  lcr_link_t l_q, l_d;
  lcr_tx_t   t_q, t_d;
  lcr_sys_t  s_q, s_d;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic              scl_s, sda_s, mode_s, wr_s, rd_s;
  logic [7:0]        sig_s;
  lcr_strap_t        strap_s;
  logic              start_det, stop_det, wr_edge, rd_edge;
  logic [7:0]        byte_v;

  assign sync_in = {i_scl, i_sda, i_cfg_mode, i_signal_present_bit,
                    i_straps, l_q.wr_tgl, l_q.rd_tgl};

  lcr_sync2 #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (sync_in),
    .o_sync  (sync_out)
  );

  assign {scl_s, sda_s, mode_s, sig_s, strap_s, wr_s, rd_s} = sync_out;

  function automatic lcr_cfg_t from_straps(input lcr_strap_t st);
    lcr_cfg_t c;
    c.lane_pair_normal_n     = {4{st.loopback_n}};
    c.group_a_halfbit_select = st.halfbit_a;
    c.group_b_halfbit_select = st.halfbit_b;
    c.input_off_bit          = RST_CHANNEL_INPUT_DISABLE;
    c.output_off_field       = RST_CHANNEL_OUTPUT_DISABLE;
    c.channel_on_bit         = {8{st.powerdown_n}};
    c.group_a_eq_output_ctrl = st.eq_out_a;
    c.group_b_eq_output_ctrl = st.eq_out_b;
    return c;
  endfunction : from_straps

  // Bit 7 of every per-channel byte is channel A0, bit 0 is B3.
  function automatic logic [7:0] read_mux(input logic [3:0] idx,
                                          input lcr_sys_t   s,
                                          input logic [7:0] sig);
    logic [7:0] r;
    r = RD_UNMAPPED;
    case (idx)
      OFS_SIG:    r = sig;                                       // R6 R7
      OFS_SPARE1: r = RD_SPARE1;                                 // R8
      OFS_LOOPBACK_DEEMPH_CTRL:  r = {s.cfg.lane_pair_normal_n,
                       s.cfg.group_a_halfbit_select,
                       s.cfg.group_b_halfbit_select, 2'h0};      // R10
      OFS_CHANNEL_INPUT_DISABLE:  r = s.cfg.input_off_bit;
      OFS_CHANNEL_OUTPUT_DISABLE: r = s.cfg.output_off_field;
      OFS_SPARE5: r = s.spare5;
      OFS_PWR:    r = s.cfg.channel_on_bit;
      OFS_EQA:    r = s.cfg.group_a_eq_output_ctrl;
      OFS_EQB:    r = s.cfg.group_b_eq_output_ctrl;
      default:    r = RD_UNMAPPED;                               // R20
    endcase
    return r;
  endfunction : read_mux

  // Bus events seen from the system clock. Toggles are ignored while the
  // link is held in reset, since clearing them would look like an event.
  assign start_det = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
  assign stop_det  = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;
  assign wr_edge   = (wr_s ^ s_q.wr_p) & s_q.link_rstn;
  assign rd_edge   = (rd_s ^ s_q.rd_p) & s_q.link_rstn;

  always_comb
  begin
    s_d       = s_q;
    s_d.scl_p = scl_s;
    s_d.sda_p = sda_s;
    s_d.wr_p  = wr_s;
    s_d.rd_p  = rd_s;
    if (!s_q.init_done)
    begin
      // Straps are caught once they have settled through the synchroniser.
      if (s_q.init_cnt == INIT_WAIT)
      begin
        s_d.init_done = 1'b1;
        s_d.addr      = {ADDR_HI_FIXED, strap_s.addr_upper, ADDR_MID_FIXED,
                         strap_s.addr_middle, strap_s.addr_lowest}; // R4 R18
        s_d.cfg       = from_straps(strap_s);             // R9 R10 R11 R12 R14
      end
      else
      begin
        s_d.init_cnt = s_q.init_cnt + 2'h1;
      end
    end
    else if (mode_s)
    begin
      s_d.cfg = from_straps(strap_s);                                  // R15
    end
    else if (wr_edge)
    begin
      case (l_q.wr_idx)
        OFS_LOOPBACK_DEEMPH_CTRL:
        begin
          s_d.cfg.lane_pair_normal_n     = l_q.wr_dat[LB_MSB:LB_LSB];  // R9
          s_d.cfg.group_a_halfbit_select = l_q.wr_dat[DEA_BIT];        // R10
          s_d.cfg.group_b_halfbit_select = l_q.wr_dat[DEB_BIT];
        end
        OFS_CHANNEL_INPUT_DISABLE:  s_d.cfg.input_off_bit          = l_q.wr_dat;       // R11
        OFS_CHANNEL_OUTPUT_DISABLE: s_d.cfg.output_off_field       = l_q.wr_dat;       // R12
        OFS_SPARE5: s_d.spare5                     = l_q.wr_dat;       // R13
        OFS_PWR:    s_d.cfg.channel_on_bit         = l_q.wr_dat;       // R14
        OFS_EQA:    s_d.cfg.group_a_eq_output_ctrl = l_q.wr_dat;
        OFS_EQB:    s_d.cfg.group_b_eq_output_ctrl = l_q.wr_dat;
        default:    s_d.cfg = s_q.cfg;                             // R8 R19
      endcase
    end
    if (rd_edge)
    begin
      s_d.rd_byte = read_mux(l_q.rd_idx, s_q, sig_s);
    end
    // START, repeated START and STOP all hold the link logic in reset.
    if (start_det | stop_det)
    begin
      s_d.clr_cnt = FRAME_CLR_LOAD;                                    // R19
    end
    else if (s_q.clr_cnt != 6'h00)
    begin
      s_d.clr_cnt = s_q.clr_cnt - 6'h01;
    end
    s_d.link_rstn = s_d.init_done & (s_d.clr_cnt == 6'h00) &
                    ~(start_det | stop_det);
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_q        <= '0;
      s_q.spare5 <= RST_SPARE5;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Link logic. The address and the read byte are held steady by the system
  // side before the link leaves reset or half a bus clock before use.
  assign byte_v = {l_q.shift[6:0], i_sda};

  always_comb
  begin
    l_d       = l_q;
    l_d.shift = byte_v;                                                 // R1
    if (l_q.bitcnt == ACK_SLOT)
    begin
      l_d.bitcnt = 4'h0;
      if (l_q.phase == L_READ && !l_q.ack_due && i_sda)
      begin
        l_d.phase = L_IGNORE;                                           // R3
      end
    end
    else
    begin
      l_d.bitcnt = l_q.bitcnt + 4'h1;
      if (l_q.bitcnt == LAST_BIT)
      begin
        case (l_q.phase)
          L_ADDR:
          begin
            if (byte_v[7:1] == s_q.addr)                           // R1 R18
            begin
              l_d.ack_due = 1'b1;
              if (byte_v[0])
              begin
                l_d.phase  = L_READ;
                l_d.rd_idx = OFS_SIG;                                   // R17
                l_d.rd_tgl = ~l_q.rd_tgl;
                l_d.ptr    = OFS_SPARE1;
              end
              else
              begin
                l_d.phase = L_INDEX;
              end
            end
            else
            begin
              l_d.phase   = L_IGNORE;
              l_d.ack_due = 1'b0;
            end
          end
          L_INDEX:
          begin
            l_d.ack_due = 1'b1;                                     // R2 R17
            l_d.phase   = L_WRITE;
          end
          L_WRITE:
          begin
            l_d.ack_due = 1'b1;                                         // R16
            if (l_q.ptr < NUM_REGS)                                     // R20
            begin
              l_d.wr_idx = l_q.ptr;                                     // R5
              l_d.wr_dat = byte_v;
              l_d.wr_tgl = ~l_q.wr_tgl;
              l_d.ptr    = l_q.ptr + 4'h1;                              // R3
            end
          end
          L_READ:
          begin
            l_d.ack_due = 1'b0;
            l_d.rd_idx  = l_q.ptr;
            l_d.rd_tgl  = ~l_q.rd_tgl;
            if (l_q.ptr < NUM_REGS)
            begin
              l_d.ptr = l_q.ptr + 4'h1;
            end
          end
          default: l_d.ack_due = 1'b0;
        endcase
      end
    end
  end

  // The data line changes only while the bus clock is low.
  always_comb
  begin
    t_d = t_q;
    if (l_q.bitcnt == ACK_SLOT)
    begin
      t_d.oe = l_q.ack_due;                                             // R16
    end
    else if (l_q.phase == L_READ)
    begin
      if (l_q.bitcnt == 4'h0)
      begin
        t_d.sh = s_q.rd_byte;
        t_d.oe = ~s_q.rd_byte[7];
      end
      else
      begin
        t_d.oe = ~t_q.sh[3'(LAST_BIT - l_q.bitcnt)];
      end
    end
    else
    begin
      t_d.oe = 1'b0;
    end
  end

  // The serial clock is an input only, so the master is never stalled.
  always_ff @(posedge i_scl or negedge s_q.link_rstn)
  begin
    if (!s_q.link_rstn)
    begin
      l_q <= '0;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  always_ff @(negedge i_scl or negedge s_q.link_rstn)
  begin
    if (!s_q.link_rstn)
    begin
      t_q <= '0;
    end
    else
    begin
      t_q <= t_d;
    end
  end

  assign o_sda    = t_q.lvl;
  assign o_sda_oe = t_q.oe;
  assign o_cfg    = s_q.cfg;

  property p_mode_follows_strap;
    @(posedge i_clk) disable iff (!i_rstn)
    (s_q.init_done && mode_s) |=>
      (s_q.cfg.channel_on_bit == {8{$past(strap_s.powerdown_n)}});
  endproperty
  a_mode_follows_strap: assert property (p_mode_follows_strap) // R15
    else $error("channel_on_bit does not follow strap in strap mode");

  property p_loopback_deemph_ctrl_low_bits;
    @(posedge i_clk) disable iff (!i_rstn)
    (rd_edge && l_q.rd_idx == OFS_LOOPBACK_DEEMPH_CTRL) |=> (s_q.rd_byte[1:0] == 2'h0);
  endproperty
  a_loopback_deemph_ctrl_low_bits: assert property (p_loopback_deemph_ctrl_low_bits) // R10
    else $error("reserved loopback byte bits read nonzero");

  property p_sig_live;
    @(posedge i_clk) disable iff (!i_rstn)
    (rd_edge && l_q.rd_idx == OFS_SIG) |=> (s_q.rd_byte == $past(sig_s));
  endproperty
  a_sig_live: assert property (p_sig_live) // R7
    else $error("signal detect read is not the live level");

  property p_disable_reset;
    @(posedge i_clk) disable iff (!i_rstn)
    $rose(s_q.init_done) |-> (s_q.cfg.input_off_bit == RST_CHANNEL_INPUT_DISABLE) &&
                             (s_q.cfg.output_off_field == RST_CHANNEL_OUTPUT_DISABLE);
  endproperty
  a_disable_reset: assert property (p_disable_reset) // R11 R12
    else $error("disable bits not cleared at start-up");

  property p_write_lands;
    @(posedge i_clk) disable iff (!i_rstn)
    (wr_edge && !mode_s && s_q.init_done && l_q.wr_idx == OFS_CHANNEL_INPUT_DISABLE) |=>
      (s_q.cfg.input_off_bit == $past(l_q.wr_dat));
  endproperty
  a_write_lands: assert property (p_write_lands) // R5
    else $error("input disable write did not land");

  property p_start_clears_link;
    @(posedge i_clk) disable iff (!i_rstn)
    start_det |=> (!s_q.link_rstn) [*8];
  endproperty
  a_start_clears_link: assert property (p_start_clears_link) // R19
    else $error("link not held clear after START");

  // An address byte with a wrong fixed bit must never be taken as ours.
  property p_addr_fixed;
    @(posedge i_scl) disable iff (!s_q.link_rstn)
    (l_q.phase == L_ADDR && l_q.bitcnt == LAST_BIT &&
     (byte_v[7:6] != ADDR_HI_FIXED || byte_v[4:3] != ADDR_MID_FIXED)) |=>
      (l_q.phase == L_IGNORE && !l_q.ack_due);
  endproperty
  a_addr_fixed: assert property (p_addr_fixed) // R18
    else $error("fixed address bits wrong");

  property p_ack_driven;
    @(posedge i_scl) disable iff (!s_q.link_rstn)
    (l_q.bitcnt == ACK_SLOT && l_q.ack_due) |-> t_q.oe;
  endproperty
  a_ack_driven: assert property (p_ack_driven) // R16
    else $error("acknowledge not driven in ack slot");

  property p_filler_dropped;
    @(posedge i_scl) disable iff (!s_q.link_rstn)
    (l_q.phase == L_INDEX && l_q.bitcnt == LAST_BIT) |=>
      ($stable(l_q.wr_tgl) && l_q.ptr == OFS_SIG);
  endproperty
  a_filler_dropped: assert property (p_filler_dropped) // R2 R17
    else $error("index byte was written or moved the pointer");

endmodule : lcr_cfg_regs

// ===== hdl/lcr_pkg.sv
package lcr_pkg;

  // Clock and frame-clear timing.
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned FRAME_CLR_NS   = 1000;
  localparam int unsigned FRAME_CLR_CYC  =
    (FRAME_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0]  FRAME_CLR_LOAD = 6'(FRAME_CLR_CYC);
  localparam logic [1:0]  INIT_WAIT      = 2'h3;

  // Register offsets.
  localparam logic [3:0] OFS_SIG      = 4'h0;
  localparam logic [3:0] OFS_SPARE1   = 4'h1;
  localparam logic [3:0] OFS_LOOPBACK_DEEMPH_CTRL    = 4'h2;
  localparam logic [3:0] OFS_CHANNEL_INPUT_DISABLE    = 4'h3;
  localparam logic [3:0] OFS_CHANNEL_OUTPUT_DISABLE   = 4'h4;
  localparam logic [3:0] OFS_SPARE5   = 4'h5;
  localparam logic [3:0] OFS_PWR      = 4'h6;
  localparam logic [3:0] OFS_SPARE7   = 4'h7;
  localparam logic [3:0] OFS_EQA      = 4'h8;
  localparam logic [3:0] OFS_EQB      = 4'h9;
  localparam logic [3:0] OFS_SPARE10  = 4'ha;
  localparam logic [3:0] OFS_SPARE11  = 4'hb;
  localparam logic [3:0] NUM_REGS     = 4'hc;

  // Field positions in the loopback and de-emphasis byte.
  localparam int LB_MSB  = 7;
  localparam int LB_LSB  = 4;
  localparam int DEA_BIT = 3;
  localparam int DEB_BIT = 2;

  // Fixed bus address bits and reset or read-back values.
  localparam logic [1:0] ADDR_HI_FIXED  = 2'h3;
  localparam logic [1:0] ADDR_MID_FIXED = 2'h0;
  localparam logic [7:0] RST_CHANNEL_INPUT_DISABLE      = 8'h00;
  localparam logic [7:0] RST_CHANNEL_OUTPUT_DISABLE     = 8'h00;
  localparam logic [7:0] RST_SPARE5     = 8'hff;
  localparam logic [7:0] RD_SPARE1      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;
  localparam logic [3:0] ACK_SLOT       = 4'h8;
  localparam logic [3:0] LAST_BIT       = 4'h7;

  typedef enum logic [2:0] {
    L_ADDR, L_INDEX, L_WRITE, L_READ, L_IGNORE
  } lcr_phase_t;

  typedef struct packed {
    logic       addr_upper;
    logic       addr_middle;
    logic       addr_lowest;
    logic       loopback_n;
    logic       powerdown_n;
    logic       halfbit_a;
    logic       halfbit_b;
    logic [7:0] eq_out_a;
    logic [7:0] eq_out_b;
  } lcr_strap_t;

  typedef struct packed {
    logic [3:0] lane_pair_normal_n;
    logic       group_a_halfbit_select;
    logic       group_b_halfbit_select;
    logic [7:0] input_off_bit;
    logic [7:0] output_off_field;
    logic [7:0] channel_on_bit;
    logic [7:0] group_a_eq_output_ctrl;
    logic [7:0] group_b_eq_output_ctrl;
  } lcr_cfg_t;

endpackage : lcr_pkg

// ===== hdl/lcr_sync2.sv
`timescale 1ns/100ps
module lcr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // Destination clock.
  input  wire logic         i_rstn,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] i_async, // Bits from another domain.
  output logic      [W-1:0] o_sync   // Bits after two flip-flops.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds the second stage only.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : lcr_sync2

// ===== tb/lane_conditioner_cfg_regs_bench.sv
`timescale 1ns/100ps
module lane_conditioner_cfg_regs_bench
  import lcr_pkg::*;
;
  // Fixed bits 11 and 00 around straps 1, 0 and 1.
  localparam logic [7:0] ADDR_W = 8'he2;
  localparam logic [7:0] ADDR_R = 8'he3;
  localparam int         LIMIT  = 95000;
  logic       i_clk;
  logic       i_rstn;
  logic       i_cfg_mode;
  logic [7:0] sig;
  lcr_strap_t straps;
  lcr_cfg_t   cfg;
  lcr_cfg_t   exp_cfg;
  logic       dut_oe;
  logic       dut_sda;
  logic       m_oe;
  logic       scl;
  logic       sda;
  logic [7:0] spare5;
  int         miscompares;
  int         cmp_count;
  int         cycles;

  // A driven line shows the device's drive level, so a wrong level is seen.
  assign sda = ~m_oe & (dut_oe ? dut_sda : 1'b1);

  lcr_cfg_regs dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda),
    .o_sda(dut_sda), .o_sda_oe(dut_oe), .i_cfg_mode(i_cfg_mode),
    .i_signal_present_bit(sig), .i_straps(straps), .o_cfg(cfg));
  lcr_bus_master mdl (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      $display("MISMATCH t=%0t run did not finish", $time);
      print_verdict();
    end
  end

  task automatic cmp8(input logic [7:0] got, exp, input int ofs);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t byte %0d got %h exp %h", $time, ofs,
               got, exp);
    end
  endtask : cmp8

  task automatic cmp_ack(input logic got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t ack got %b exp %b", $time, got, exp);
    end
  endtask : cmp_ack

  task automatic cmp_cfg();
    cmp_count++;
    if (cfg !== exp_cfg)
    begin
      miscompares++;
      $display("MISMATCH t=%0t cfg got %h exp %h", $time, cfg, exp_cfg);
    end
  endtask : cmp_cfg

  function automatic logic [7:0] exp_byte(input int ofs);
    case (ofs)
      0: return sig;
      2: return {exp_cfg.lane_pair_normal_n, exp_cfg.group_a_halfbit_select,
                 exp_cfg.group_b_halfbit_select, 2'b00};
      3: return exp_cfg.input_off_bit;
      4: return exp_cfg.output_off_field;
      5: return spare5;
      6: return exp_cfg.channel_on_bit;
      8: return exp_cfg.group_a_eq_output_ctrl;
      9: return exp_cfg.group_b_eq_output_ctrl;
      default: return 8'h00;
    endcase
  endfunction : exp_byte

  task automatic exp_from_straps();
    exp_cfg.lane_pair_normal_n     = {4{straps.loopback_n}};
    exp_cfg.group_a_halfbit_select = straps.halfbit_a;
    exp_cfg.group_b_halfbit_select = straps.halfbit_b;
    exp_cfg.input_off_bit          = 8'h00;
    exp_cfg.output_off_field       = 8'h00;
    exp_cfg.channel_on_bit         = {8{straps.powerdown_n}};
    exp_cfg.group_a_eq_output_ctrl = straps.eq_out_a;
    exp_cfg.group_b_eq_output_ctrl = straps.eq_out_b;
  endtask : exp_from_straps

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    mdl.put_byte(b, ack);
    cmp_ack(ack, exp_ack);
  endtask : send

  // Called with the clock low it opens with a repeated START.
  task automatic read_regs(input int n);
    logic [7:0] rd;
    mdl.start();
    send(ADDR_R, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      mdl.get_byte(i < n - 1, rd);
      cmp8(rd, exp_byte(i), i);
    end
    mdl.stop();
  endtask : read_regs

  task automatic t_power_on();
    exp_from_straps();
    cmp_cfg();
    read_regs(13);
  endtask : t_power_on

  task automatic t_write_back();
    logic [7:0] wr [13] = '{8'hff, 8'h12, 8'h5b, 8'h81, 8'h42, 8'hff,
                            8'h3c, 8'h77, 8'hc3, 8'h18, 8'h99, 8'h66, 8'h55};
    mdl.start();
    send(ADDR_W, 1'b1);
    send(8'h07, 1'b1);
    for (int i = 0; i < 13; i++)
      send(wr[i], 1'b1);
    exp_cfg = '{4'h5, 1'b1, 1'b0, 8'h81, 8'h42, 8'h3c, 8'hc3, 8'h18};
    @(posedge i_clk);
    #1 sig = 8'h69;
    read_regs(13);
    cmp_cfg();
  endtask : t_write_back

  task automatic t_partial();
    mdl.start();
    send(ADDR_W, 1'b1);
    send(8'h00, 1'b1);
    send(8'h00, 1'b1);
    send(8'h00, 1'b1);
    send(8'hf4, 1'b1);
    mdl.stop();
    exp_cfg.lane_pair_normal_n     = 4'hf;
    exp_cfg.group_a_halfbit_select = 1'b0;
    exp_cfg.group_b_halfbit_select = 1'b1;
    read_regs(3);
    cmp_cfg();
  endtask : t_partial

  task automatic t_wrong_addr();
    logic [7:0] bad [4] = '{8'he0, 8'hc2, 8'hf2, 8'h62};
    for (int i = 0; i < 4; i++)
    begin
      mdl.start();
      send(bad[i], 1'b0);
      send(8'h00, 1'b0);
      mdl.stop();
    end
    cmp_cfg();
  endtask : t_wrong_addr

  task automatic t_mode_high();
    @(posedge i_clk);
    #1 i_cfg_mode = 1'b1;
    straps.loopback_n  = 1'b0;
    straps.powerdown_n = 1'b1;
    straps.eq_out_a    = 8'h11;
    repeat (10) @(posedge i_clk);
    // Keep the bus edges and the compare off the system clock edge.
    #1;
    exp_from_straps();
    cmp_cfg();
    mdl.start();
    send(ADDR_W, 1'b1);
    for (int i = 0; i < 6; i++)
      send(8'h00, 1'b1);
    mdl.stop();
    cmp_cfg();
  endtask : t_mode_high

  initial
  begin
    miscompares = 0;
    cmp_count   = 0;
    cycles      = 0;
    i_rstn      = 1'b0;
    i_cfg_mode  = 1'b0;
    sig         = 8'h96;
    spare5      = RST_SPARE5;
    straps      = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h5a, 8'ha5};
    repeat (8) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    repeat (20) @(posedge i_clk);
    // The bus model's edges would otherwise fall on system clock edges.
    #1;
    t_power_on();
    t_write_back();
    t_partial();
    t_wrong_addr();
    t_mode_high();
    print_verdict();
  end
endmodule : lane_conditioner_cfg_regs_bench

// ===== tb/lcr_bus_master.sv
`timescale 1ns/100ps
module lcr_bus_master #(
  parameter int Q = 640 // Quarter of a serial clock period in ns.
) (
  input  wire logic i_sda,   // Resolved data line.
  output logic      o_scl,   // Serial clock, high while idle.
  output logic      o_sda_oe // High pulls the data line low.
);
  // The clock runs faster than nominal to keep the run short.
  // Two phases still clear the frame window after START and STOP.
  initial
  begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic start();
    if (!o_scl)
    begin
      #Q o_sda_oe = 1'b0;
      #Q o_scl = 1'b1;
    end
    #Q o_sda_oe = 1'b1;
    #(2*Q) o_scl = 1'b0;
  endtask : start

  task automatic stop();
    #Q o_sda_oe = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_oe = 1'b0;
    #(2*Q);
  endtask : stop

  // A level that moves while the clock is high comes back unknown.
  task automatic clk_bit(input logic drv_low, output logic got);
    logic s1;
    #Q o_sda_oe = drv_low;
    #Q o_scl = 1'b1;
    s1 = i_sda;
    #Q got = (s1 === i_sda) ? s1 : 1'bx;
    #Q o_scl = 1'b0;
  endtask : clk_bit

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
      clk_bit(~b[i], g);
    clk_bit(1'b0, g);
    ack = (g === 1'b0);
  endtask : put_byte

  task automatic get_byte(input logic ack_it, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b0, g);
      b[i] = g;
    end
    clk_bit(ack_it, g);
  endtask : get_byte
endmodule : lcr_bus_master
